// ==== bench/lmsim_master.sv ====
// Remote master model issuing acknowledge and clear pulses
module lmsim_master (
	input wire clk,
	output logic [2:0] lm_ack,
	output logic [2:0] ec_up_ack,
	output logic [2:0] ec_lo_ack,
	output logic [2:0] ec_up_clr,
	output logic [2:0] ec_lo_clr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {lm_ack, ec_up_ack, ec_lo_ack, ec_up_clr, ec_lo_clr} = '0;
	// One-cycle command: 0 monitor ack, 1/2 counter acks, 3/4 counter clears
	task send(input int k, input logic [2:0] m);
		@(negedge clk);
		lm_ack = (k == 0) ? m : 3'h0;
		ec_up_ack = (k == 1) ? m : 3'h0;
		ec_lo_ack = (k == 2) ? m : 3'h0;
		ec_up_clr = (k == 3) ? m : 3'h0;
		ec_lo_clr = (k == 4) ? m : 3'h0;
		@(negedge clk);
		{lm_ack, ec_up_ack, ec_lo_ack, ec_up_clr, ec_lo_clr} = '0;
	endtask
endmodule

// ==== bench/lmsim_properties.sv ====
// Port checker for the limit monitor and simulation block
module lmsim_props #(
	parameter W = 16,
	parameter CW = 16,
	parameter TW = 24
) (
	input wire clk,
	input wire srst,
	input wire [W-1:0] meas_press,
	input wire [W-1:0] press_q,
	input wire [2:0] sim_start,
	input wire [2:0] sim_active,
	input wire [2:0] lm_warn,
	input wire [2:0] lm_irq,
	input wire [2:0] lm_irq_en,
	input wire [3*TW-1:0] lm_stopt,
	input wire [2:0] ec_up_warn,
	input wire [2:0] ec_up_irq,
	input wire [2:0] ec_lo_irq,
	input wire [3*CW-1:0] ec_up_cnt,
	input wire [3*CW-1:0] ec_up_cmp,
	input wire [2:0] ec_up_clr,
	input wire fault_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_fault_from_irq: assert property (!$past(srst) |-> fault_q == $past(|{lm_irq, ec_up_irq, ec_lo_irq}))
		else $error("fault state not one cycle after interrupts");
	a_irq_with_warn: assert property ((lm_irq & ~lm_warn) == 3'h0)
		else $error("interrupt without warning");
	a_irq_en_gate: assert property (((lm_irq & ~$past(lm_irq)) & ~$past(lm_irq_en)) == 3'h0)
		else $error("interrupt raised while disabled");
	a_sim_start_on: assert property (sim_start[0] |=> sim_active[0])
		else $error("pressure path not active after start");
	a_restart_off: assert property ($fell(srst) |-> sim_active == 3'h0)
		else $error("simulation survived restart");
	a_press_measured: assert property (!$past(srst) && !$past(sim_active[0]) |-> press_q == $past(meas_press))
		else $error("pressure not from process while idle");
	a_warn_hold: assert property ($rose(lm_warn[0]) && lm_stopt[TW-1:0] >= 3 |=> lm_warn[0] [*2])
		else $error("warning dropped inside stop time");
	a_ec_fire_count: assert property ($rose(ec_up_warn[0]) |-> ec_up_cnt[CW-1:0] >= ec_up_cmp[CW-1:0])
		else $error("counter event below comparison value");
	a_ec_clear_zero: assert property (ec_up_clr[0] |=> ec_up_cnt[CW-1:0] <= 1)
		else $error("counter not cleared");
	c_warn: cover property ($rose(lm_warn[0]));
	c_ec_warn: cover property ($rose(ec_up_warn[0]));
	c_fault: cover property ($rose(fault_q));
endmodule
bind lmsim_top lmsim_props #(.W(W), .CW(CW), .TW(TW)) lmsim_props_inst (.*);

// ==== bench/lmsim_top_tb.sv ====
// Self-checking bench for the limit monitor and simulation block
module lmsim_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst;
	logic [15:0] meas_press, meas_stemp, meas_etemp;
	logic [2:0] sim_start, sim_stop, sim_ramp, lm_en, lm_irq_en, ec_en, ec_up_irq_en, ec_lo_irq_en;
	logic [47:0] sim_fixed, sim_lo, sim_hi, lm_upper, lm_lower, lm_hyst, ec_up_cmp, ec_lo_cmp;
	logic [23:0] sim_steps;
	logic [71:0] sim_dwell, lm_resp, lm_stopt;
	logic [5:0] lm_sel, lm_chk;
	wire [2:0] lm_ack, ec_up_ack, ec_lo_ack, ec_up_clr, ec_lo_clr, sim_active, lm_warn, lm_irq;
	wire [2:0] ec_up_warn, ec_up_irq, ec_lo_warn, ec_lo_irq;
	wire [15:0] press_q, stemp_q, etemp_q;
	wire [47:0] ec_up_cnt, ec_lo_cnt;
	wire fault_q;
	int err_count, cmp_count, cyc, n;
	int exp_ramp[5] = '{4, 8, 12, 16, 12};
	lmsim_top lmsim_top_inst (.*);
	lmsim_master lmsim_master_inst (.*);
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_count++;
			print_verdict();
		end
	end
	task tick(int n);
		repeat (n) @(negedge clk);
	endtask
	task chk(string name, logic [47:0] exp, logic [47:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Start pulse on the chosen simulation paths
	task start(logic [2:0] p);
		sim_start = p;
		tick(1);
		sim_start = 3'h0;
	endtask
	// Wait until the pressure output moves, bounded; report the cycles waited
	task wchg(output int cnt);
		logic [15:0] p;
		p = press_q;
		cnt = 0;
		while (cnt < 20 && press_q === p)
		begin
			tick(1);
			cnt++;
		end
	endtask
	task print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		{sim_start, sim_stop, sim_ramp, lm_en, lm_irq_en, ec_en, ec_up_irq_en, ec_lo_irq_en} = '0;
		{sim_fixed, sim_lo, sim_hi, lm_upper, lm_lower, lm_hyst, ec_up_cmp, ec_lo_cmp} = '0;
		{sim_steps, sim_dwell, lm_resp, lm_stopt, lm_sel, lm_chk} = '0;
		{meas_press, meas_stemp, meas_etemp} = {16'h0050, 16'h0020, 16'h0030};
		srst = 1;
		tick(4);
		srst = 0;
		chk("sim_active", 0, sim_active);
		tick(2);
		chk("press_q", 16'h0050, press_q);
		chk("etemp_q", 16'h0030, etemp_q);
		// Monitor 0 upper on pressure, monitor 1 lower on sensor temperature
		{lm_en, lm_chk, lm_irq_en, lm_sel, ec_en, ec_lo_irq_en} = {3'h1, 6'h01, 3'h1, 6'h04, 3'h3, 3'h2};
		{lm_upper, lm_lower, lm_hyst} = {48'h0200, 48'h00800000, 48'h00100010};
		{lm_resp, lm_stopt, ec_up_cmp, ec_lo_cmp} = {72'h000003000003, 72'h000003000014, 48'h1, 48'h00010000};
		sim_fixed = 48'h70000300;
		start(3'h3);
		tick(2);
		chk("sim_active", 3'h3, sim_active);
		chk("press_q", 16'h0300, press_q);
		chk("stemp_q", 16'h7000, stemp_q);
		chk("lm_warn", 0, lm_warn);
		meas_press = 16'h0060;
		tick(8);
		chk("press_q", 16'h0300, press_q);
		chk("lm_irq", 3'h1, lm_irq);
		chk("fault_q", 1, fault_q);
		chk("ec_up_cnt", 1, ec_up_cnt);
		chk("ec_up_warn", 3'h1, ec_up_warn);
		chk("ec_up_irq", 3'h0, ec_up_irq);
		sim_fixed[15:0] = 16'h0100;
		lmsim_master_inst.send(0, 3'h1);
		tick(2);
		chk("lm_warn", 3'h1, lm_warn);
		tick(20);
		chk("lm_warn", 0, lm_warn);
		chk("ec_up_warn", 3'h1, ec_up_warn);
		lmsim_master_inst.send(1, 3'h1);
		tick(1);
		chk("ec_up_warn", 0, ec_up_warn);
		sim_fixed[15:0] = 16'h0300;
		tick(10);
		chk("ec_up_cnt", 2, ec_up_cnt);
		chk("ec_up_warn", 0, ec_up_warn);
		lmsim_master_inst.send(3, 3'h1);
		tick(1);
		chk("ec_up_cnt", 0, ec_up_cnt);
		lmsim_master_inst.send(0, 3'h1);
		lm_en = 3'h3;
		lm_chk = 6'h09;
		sim_fixed[31:16] = 16'h0010;
		tick(10);
		chk("lm_warn1", 1, lm_warn[1]);
		chk("lm_irq1", 0, lm_irq[1]);
		chk("ec_lo_cnt1", 1, ec_lo_cnt[31:16]);
		chk("ec_lo_warn", 3'h2, ec_lo_warn);
		chk("ec_lo_irq", 3'h2, ec_lo_irq);
		chk("fault_q", 1, fault_q);
		sim_fixed[31:16] = 16'h0085;
		lmsim_master_inst.send(0, 3'h2);
		tick(8);
		chk("lm_warn1", 1, lm_warn[1]);
		sim_fixed[31:16] = 16'h00a0;
		tick(4);
		chk("lm_warn1", 0, lm_warn[1]);
		// Ramp 0 to 16 in four steps, three cycles each
		{sim_ramp, sim_lo, sim_hi, sim_steps, sim_dwell} = {3'h1, 48'h0, 48'h10, 24'h4, 72'h3};
		start(3'h1);
		tick(2);
		chk("press_q", 0, press_q);
		foreach (exp_ramp[i])
		begin
			wchg(n);
			chk("press_q", exp_ramp[i], press_q);
			if (i > 0)
				chk("ramp_dwell", 3, n);
		end
		// Stop the pressure path; the sensor temperature path stays on
		sim_stop = 3'h1;
		tick(1);
		sim_stop = 3'h0;
		tick(2);
		chk("sim_active", 3'h2, sim_active);
		chk("press_q", 16'h0060, press_q);
		// Monitor 2 on electronics temperature, upper check only
		lm_sel[5:4] = 2'h2;
		lm_chk[5:4] = 2'h1;
		lm_upper[47:32] = 16'h0040;
		tick(2);
		lm_en = 3'h7;
		tick(3);
		chk("lm_warn2", 0, lm_warn[2]);
		meas_etemp = 16'h0050;
		tick(4);
		chk("lm_warn2", 1, lm_warn[2]);
		chk("lm_irq2", 0, lm_irq[2]);
		srst = 1;
		tick(1);
		srst = 0;
		tick(2);
		chk("sim_active", 0, sim_active);
		chk("press_q", 16'h0060, press_q);
		print_verdict();
	end
endmodule

// ==== hdl/lmsim_top.v ====
// Limit monitors with event counters and three simulation sources
`include "lmsim_map.vh"

module lmsim_top #(
	parameter W = `LMSIM_VAL_W,
	parameter CW = `LMSIM_CNT_W,
	parameter TW = `LMSIM_TIM_W,
	parameter SW = `LMSIM_STP_W
) (
	input wire clk,
	input wire srst,
	// Measured values, same clock domain
	input wire [W-1:0] meas_press,
	input wire [W-1:0] meas_stemp,
	input wire [W-1:0] meas_etemp,
	// Simulation control, one bit or slice per path: 0 press, 1 stemp, 2 etemp
	input wire [2:0] sim_start,
	input wire [2:0] sim_stop,
	input wire [2:0] sim_ramp,
	input wire [3*W-1:0] sim_fixed,
	input wire [3*W-1:0] sim_lo,
	input wire [3*W-1:0] sim_hi,
	input wire [3*SW-1:0] sim_steps,
	input wire [3*TW-1:0] sim_dwell,
	// Limit monitor configuration, one slice per monitor
	input wire [2:0] lm_en,
	input wire [5:0] lm_sel,
	input wire [5:0] lm_chk,
	input wire [2:0] lm_irq_en,
	input wire [3*W-1:0] lm_upper,
	input wire [3*W-1:0] lm_lower,
	input wire [3*W-1:0] lm_hyst,
	input wire [3*TW-1:0] lm_resp,
	input wire [3*TW-1:0] lm_stopt,
	input wire [2:0] lm_ack,
	// Event counter configuration
	input wire [2:0] ec_en,
	input wire [2:0] ec_up_irq_en,
	input wire [2:0] ec_lo_irq_en,
	input wire [3*CW-1:0] ec_up_cmp,
	input wire [3*CW-1:0] ec_lo_cmp,
	input wire [2:0] ec_up_clr,
	input wire [2:0] ec_lo_clr,
	input wire [2:0] ec_up_ack,
	input wire [2:0] ec_lo_ack,
	// Results
	output reg [W-1:0] press_q,
	output reg [W-1:0] stemp_q,
	output reg [W-1:0] etemp_q,
	output wire [2:0] sim_active,
	output wire [2:0] lm_warn,
	output wire [2:0] lm_irq,
	output wire [2:0] ec_up_warn,
	output wire [2:0] ec_up_irq,
	output wire [2:0] ec_lo_warn,
	output wire [2:0] ec_lo_irq,
	output wire [3*CW-1:0] ec_up_cnt,
	output wire [3*CW-1:0] ec_lo_cnt,
	output reg fault_q
);

	////////////////////////////////////////////////////////////////
	// Helpers

	// Pick one device variable by code; every variable always listed
	function [W-1:0] pick_var;
		input [1:0] sel;
		input [3*W-1:0] vars;
		begin
			if (sel == `LMSIM_VAR_STEMP)
				pick_var = vars[W +: W];
			else if (sel == `LMSIM_VAR_ETEMP)
				pick_var = vars[2*W +: W];
			else
				pick_var = vars[0 +: W];
		end
	endfunction

	// Sign extend by one bit for overflow free arithmetic
	function [W:0] sx;
		input [W-1:0] v;
		begin
			sx = {v[W-1], v};
		end
	endfunction

	wire [3*W-1:0] sim_val; // Current simulated value per path
	wire [3*W-1:0] eff_vars; // Variables as the monitors see them

	////////////////////////////////////////////////////////////////
	// Simulation paths

	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1)
		begin : g_sim
			reg act_q; // Path active
			reg ramp_q; // Ramp rather than fixed
			reg up_q; // Ramp direction rising
			reg [W-1:0] val_q; // Simulated value
			reg [W-1:0] inc_q; // Step width
			reg [TW-1:0] dwell_q; // Cycles spent on this step
			wire [W-1:0] lo = sim_lo[p*W +: W];
			wire [W-1:0] hi = sim_hi[p*W +: W];
			wire [SW-1:0] stp = sim_steps[p*SW +: SW];
			wire [TW-1:0] dur = sim_dwell[p*TW +: TW];
			wire [W:0] span = sx(hi) - sx(lo);
			wire [SW-1:0] div = (stp == {SW{1'b0}}) ? {{(SW-1){1'b0}}, 1'b1} : stp;
			wire [W:0] quo = span / {{(W+1-SW){1'b0}}, div};
			wire [W:0] nxt_up = sx(val_q) + {1'b0, inc_q};
			wire [W:0] nxt_dn = sx(val_q) - {1'b0, inc_q};
			wire step_due = (dwell_q + {{(TW-1){1'b0}}, 1'b1}) >= dur;
			wire top = $signed(nxt_up) >= $signed(sx(hi)); // Next rising step reaches the top
			wire bot = $signed(nxt_dn) <= $signed(sx(lo)); // Next falling step reaches the bottom
			// Path state; reset turns simulation off
			always @(posedge clk)
			begin
				if (srst)
				begin
					act_q <= `LMSIM_RST_FLAG;
					ramp_q <= 1'b0;
					up_q <= 1'b1;
					val_q <= {W{1'b0}};
					inc_q <= {W{1'b0}};
					dwell_q <= {TW{1'b0}};
				end
				else if (sim_start[p])
				begin
					// Load mode and start point
					act_q <= 1'b1;
					ramp_q <= sim_ramp[p];
					up_q <= 1'b1;
					val_q <= sim_ramp[p] ? lo : sim_fixed[p*W +: W];
					inc_q <= quo[W-1:0];
					dwell_q <= {TW{1'b0}};
				end
				else if (sim_stop[p])
					act_q <= 1'b0;
				else if (act_q && !ramp_q)
					val_q <= sim_fixed[p*W +: W]; // Fixed value follows setting
				else if (act_q)
				begin
					// Ramp: hold each step for the dwell, then move
					if (step_due)
					begin
						// Clamp at either end and turn round
						dwell_q <= {TW{1'b0}};
						val_q <= up_q ? (top ? hi : nxt_up[W-1:0]) : (bot ? lo : nxt_dn[W-1:0]);
						up_q <= up_q ? !top : bot;
					end
					else
						dwell_q <= dwell_q + {{(TW-1){1'b0}}, 1'b1};
				end
			end
			assign sim_active[p] = act_q;
			assign sim_val[p*W +: W] = val_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Variable selection

	// Each output follows its simulation path while active, else the measured value
	always @(posedge clk)
	begin
		if (srst)
		begin
			press_q <= {W{1'b0}};
			stemp_q <= {W{1'b0}};
			etemp_q <= {W{1'b0}};
		end
		else
		begin
			press_q <= sim_active[0] ? sim_val[0 +: W] : meas_press;
			stemp_q <= sim_active[1] ? sim_val[W +: W] : meas_stemp;
			etemp_q <= sim_active[2] ? sim_val[2*W +: W] : meas_etemp;
		end
	end

	assign eff_vars = {etemp_q, stemp_q, press_q};

	////////////////////////////////////////////////////////////////
	// Limit monitors and event counters

	genvar m;
	generate
		for (m = 0; m < 3; m = m + 1)
		begin : g_mon
			reg hi_q; // Above upper limit, with hysteresis
			reg lo_q; // Below lower limit, with hysteresis
			reg [TW-1:0] resp_q; // Cycles the violation has persisted
			reg reg_q; // Violation registered
			reg [TW-1:0] stop_q; // Remaining hold time
			reg msg_q; // Monitor message standing
			reg ackd_q; // Monitor message acknowledged
			reg irq_q; // Monitor message carries interrupt
			reg [CW-1:0] cu_q; // Upper violation count
			reg [CW-1:0] cl_q; // Lower violation count
			reg fu_q; // Upper counter event fired
			reg fl_q; // Lower counter event fired
			reg uw_q; // Upper counter warning
			reg ui_q; // Upper counter interrupt
			reg lw_q; // Lower counter warning
			reg li_q; // Lower counter interrupt
			wire [W-1:0] v = pick_var(lm_sel[2*m +: 2], eff_vars);
			wire [W:0] up = sx(lm_upper[m*W +: W]);
			wire [W:0] lw = sx(lm_lower[m*W +: W]);
			wire [W:0] hy = {1'b0, lm_hyst[m*W +: W]};
			wire [W:0] up_rel = up - hy;
			wire [W:0] lo_rel = lw + hy;
			wire [1:0] chk = lm_chk[2*m +: 2];
			wire raw = lm_en[m] && ((chk[`LMSIM_CHK_UP] && hi_q) || (chk[`LMSIM_CHK_LO] && lo_q));
			wire [TW-1:0] resp_t = lm_resp[m*TW +: TW];
			wire hit = raw && !reg_q && (resp_q + {{(TW-1){1'b0}}, 1'b1} >= resp_t);
			wire cnt_up = hit && ec_en[m] && hi_q && chk[`LMSIM_CHK_UP];
			wire cnt_lo = hit && ec_en[m] && lo_q && chk[`LMSIM_CHK_LO];
			wire [CW-1:0] cu_n = ec_up_clr[m] ? {{(CW-1){1'b0}}, cnt_up} : cu_q + {{(CW-1){1'b0}}, cnt_up};
			wire [CW-1:0] cl_n = ec_lo_clr[m] ? {{(CW-1){1'b0}}, cnt_lo} : cl_q + {{(CW-1){1'b0}}, cnt_lo};
			wire fire_u = ec_en[m] && !fu_q && !ec_up_clr[m] && cnt_up && (cu_n >= ec_up_cmp[m*CW +: CW]);
			wire fire_l = ec_en[m] && !fl_q && !ec_lo_clr[m] && cnt_lo && (cl_n >= ec_lo_cmp[m*CW +: CW]);

			// Hysteresis band on each limit
			always @(posedge clk)
			begin
				if (srst)
				begin
					hi_q <= 1'b0;
					lo_q <= 1'b0;
				end
				else
				begin
					if ($signed(sx(v)) > $signed(up))
						hi_q <= 1'b1;
					else if ($signed(sx(v)) < $signed(up_rel))
						hi_q <= 1'b0;
					if ($signed(sx(v)) < $signed(lw))
						lo_q <= 1'b1;
					else if ($signed(sx(v)) > $signed(lo_rel))
						lo_q <= 1'b0;
				end
			end

			// Response timer, registration, stop timer and message
			always @(posedge clk)
			begin
				if (srst)
				begin
					resp_q <= {TW{1'b0}};
					reg_q <= 1'b0;
					stop_q <= {TW{1'b0}};
					msg_q <= 1'b0;
					ackd_q <= 1'b0;
					irq_q <= 1'b0;
				end
				else
				begin
					// Any gap in the violation restarts the response time
					if (!raw)
						resp_q <= {TW{1'b0}};
					else if (!reg_q)
						resp_q <= resp_q + {{(TW-1){1'b0}}, 1'b1};
					reg_q <= raw && (reg_q || hit);
					if (hit)
					begin
						// New registration: raise and arm hold time
						msg_q <= 1'b1;
						irq_q <= lm_irq_en[m];
						ackd_q <= 1'b0;
						stop_q <= lm_stopt[m*TW +: TW];
					end
					else
					begin
						if (stop_q != {TW{1'b0}})
							stop_q <= stop_q - {{(TW-1){1'b0}}, 1'b1};
						if (lm_ack[m])
							ackd_q <= 1'b1;
						// Drop only once hold elapsed, violation gone and acknowledged
						if (stop_q == {TW{1'b0}} && !raw && (ackd_q || lm_ack[m]))
						begin
							msg_q <= 1'b0;
							irq_q <= 1'b0;
						end
					end
				end
			end

			// Event counters with one shot events
			always @(posedge clk)
			begin
				if (srst)
				begin
					cu_q <= {CW{1'b0}};
					cl_q <= {CW{1'b0}};
					fu_q <= 1'b0;
					fl_q <= 1'b0;
					uw_q <= 1'b0;
					ui_q <= 1'b0;
					lw_q <= 1'b0;
					li_q <= 1'b0;
				end
				else
				begin
					cu_q <= cu_n;
					cl_q <= cl_n;
					// Fired flags hold until the counter is cleared
					fu_q <= fire_u | (fu_q & !ec_up_clr[m]);
					fl_q <= fire_l | (fl_q & !ec_lo_clr[m]);
					// Set wins over acknowledge
					uw_q <= fire_u | (uw_q & !ec_up_ack[m]);
					ui_q <= fire_u ? ec_up_irq_en[m] : (ui_q & !ec_up_ack[m]);
					lw_q <= fire_l | (lw_q & !ec_lo_ack[m]);
					li_q <= fire_l ? ec_lo_irq_en[m] : (li_q & !ec_lo_ack[m]);
				end
			end
			assign lm_warn[m] = msg_q;
			assign lm_irq[m] = irq_q;
			assign ec_up_warn[m] = uw_q;
			assign ec_up_irq[m] = ui_q;
			assign ec_lo_warn[m] = lw_q;
			assign ec_lo_irq[m] = li_q;
			assign ec_up_cnt[m*CW +: CW] = cu_q;
			assign ec_lo_cnt[m*CW +: CW] = cl_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Fault current request

	// Any standing interrupt forces the fault current; warnings do not
	always @(posedge clk)
	begin
		if (srst)
			fault_q <= 1'b0;
		else
			fault_q <= |{lm_irq, ec_up_irq, ec_lo_irq};
	end
endmodule

// ==== include/lmsim_map.vh ====
// Constants for the limit monitor and simulation block
`ifndef LMSIM_MAP_VH
`define LMSIM_MAP_VH
// Default widths
`define LMSIM_VAL_W 16
`define LMSIM_CNT_W 16
`define LMSIM_TIM_W 24
`define LMSIM_STP_W 8
// Variable selection codes
`define LMSIM_VAR_PRESS 2'h0
`define LMSIM_VAR_STEMP 2'h1
`define LMSIM_VAR_ETEMP 2'h2
// Check mode bit positions
`define LMSIM_CHK_UP 0
`define LMSIM_CHK_LO 1
// Reset values
`define LMSIM_RST_FLAG 1'h0
`endif
